// ---- core/sctp_target.sv ----
// sctp_target: i2c target port with wake, word address decode and command fifo
// assumes: scl/sda pins are asynchronous; exec_done comes from core-clock logic
// limitation: only write groups are taken here; the read data path is a later stage
`timescale 1ns/1ps

// Overview of operation
// - asleep, only sda low past wake time wakes; ready after wake delay
// - asleep, idle or waking, scl and bus conditions are ignored
// - a wake sequence while awake does nothing
// - data bit sampled on scl rise; sda changes only while scl low
// - sda fall with scl high is start; begins new transaction
// - stop ends transaction; complete command enters busy and executes
// - receiver pulls sda low on ninth clock to acknowledge
// - leaving sda high on ninth clock is not acknowledge
// - seven address bits msb first must match; eighth bit zero means write
// - word address 0x00 resets the buffer address counter
// - word address 0x01 sleeps and clears volatile state
// - word address 0x02 idles, keeping key and seed stores
// - word address 0x03 appends data bytes to input buffer
// - first byte is count; bytes past count ignored until done
// - group is count, packet and two crc bytes
// - one group may span several write transactions
// - address read not acknowledged while executing
// - sda only pulled low or released, never driven high
// - bytes beyond count or 71-byte buffer are not acknowledged
// - read address not acknowledged while busy, idle or asleep
module sctp_target #(
  parameter int          BUF_DEPTH  = sctp_pkg::BUF_BYTES,
  parameter int          WAKE_LOW   = sctp_pkg::WAKE_LOW_CYCLES,
  parameter int          WAKE_READY = sctp_pkg::WAKE_READY_CYCLES,
  parameter int          EXEC_MAX   = sctp_pkg::EXEC_CYCLES,
  parameter logic [6:0]  DEV_ADDR   = sctp_pkg::ADDR_RESET
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // execution engine
  input  wire logic       exec_done,
  output logic            exec_start,
  output logic [6:0]      exec_count,
  output logic            busy,
  output logic            asleep,
  output logic            keep_clear
);

  // ==========================================================================
  // elaboration checks
  initial begin
    if (BUF_DEPTH < 4 || BUF_DEPTH > 127) $error("BUF_DEPTH out of range");
    if (WAKE_LOW < 1 || WAKE_READY < 1 || EXEC_MAX < 1) $error("timing must be positive");
    // the wake timer is 17 bits wide; longer times need a wider counter
    if (WAKE_LOW > 131071 || WAKE_READY > 131071) $error("wake timer too narrow");
  end

  // ==========================================================================
  // pin synchronisers; first stage read only by the second
  // a third stage keeps the previous level for edge detection
  logic [1:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge core_clk) begin
    s1_reg <= {scl_in, sda_in};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  sctp_pkg::sctp_bus_t now_b, was_b;
  assign now_b = sctp_pkg::sctp_bus_t'(s2_reg);
  assign was_b = sctp_pkg::sctp_bus_t'(s3_reg);

  logic scl_rise, scl_fall, start_cond, stop_cond;
  // rise and fall are one-cycle pulses on core clock
  // bit edge detection
  assign scl_rise   = now_b.scl & ~was_b.scl;
  assign scl_fall   = ~now_b.scl & was_b.scl;
  // scl high in both samples, so an sda change racing an scl edge is not a condition
  // start and stop detect
  assign start_cond = now_b.scl & was_b.scl & was_b.sda & ~now_b.sda;
  assign stop_cond  = now_b.scl & was_b.scl & ~was_b.sda & now_b.sda;

  // ==========================================================================
  // address decode, shared by the write and read branches
  // compares the upper seven bits only; the eighth is the direction bit
  function automatic logic addr_hit(input logic [7:0] b);
    return b[7:1] == DEV_ADDR;
  endfunction : addr_hit

  // ==========================================================================
  // state
  // limitation: exec_done is trusted to arrive; there is no local execution
  // watchdog, so EXEC_MAX only bounds what the engine may take
  // bytes past the count are still shifted in, but are neither acknowledged nor written to the buffer
  sctp_pkg::sctp_pwr_t   pwr_reg, pwr_next;
  // protocol state and its return point after an ack slot
  sctp_pkg::sctp_proto_t pr_reg, pr_next, ret_reg, ret_next;
  logic [16:0] tmr_reg, tmr_next;     // wake low / ready counter
  logic [3:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic [6:0]  wptr_reg, wptr_next;   // input fifo write position
  logic [6:0]  cnt_reg, cnt_next;     // group count from first byte
  logic        ack_reg, ack_next;     // pull low during ack slot
  logic        busy_reg, busy_next;
  logic        start_reg, start_next;
  logic        sda_reg, sda_next;
  logic        keep_reg, keep_next;
  logic        asleep_reg, asleep_next;
  logic [7:0]  mem_reg [BUF_DEPTH];
  logic        wr_en;

  // ==========================================================================
  // next-state logic
  // everything runs on core clock; bus events are seen two to three cycles
  // late, well inside the low phase of a 1 MHz bus clock
  // trade-off: one flat machine keeps power and protocol state in step
  always_comb begin
    // state holds, pulses default low
    pwr_next   = pwr_reg;
    pr_next    = pr_reg;
    ret_next   = ret_reg;
    tmr_next   = tmr_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    wptr_next  = wptr_reg;
    cnt_next   = cnt_reg;
    ack_next   = ack_reg;
    busy_next  = busy_reg;
    start_next = 1'b0;
    keep_next  = 1'b0;
    sda_next   = 1'b0;
    wr_en      = 1'b0;
    case (pwr_reg)
      sctp_pkg::SCTP_SLEEP, sctp_pkg::SCTP_IDLE: begin
        // count sda low time; scl ignored here
        // short low pulses restart the count; only a long low adds up to a wake
        if (now_b.sda) begin
          tmr_next = '0;
        end else if (tmr_reg >= 17'(WAKE_LOW)) begin
          pwr_next = sctp_pkg::SCTP_WAKING;
          tmr_next = '0;
        end else begin
          tmr_next = tmr_reg + 17'd1;
        end
      end
      sctp_pkg::SCTP_WAKING: begin
        // wake ready delay before bus is honoured
        // sda and scl are ignored until the delay has run out
        // the timer was cleared on entry, so it counts from the wake
        if (tmr_reg >= 17'(WAKE_READY)) begin
          pwr_next = sctp_pkg::SCTP_AWAKE;
          pr_next  = sctp_pkg::SCTP_P_WAIT;
        end else begin
          tmr_next = tmr_reg + 17'd1;
        end
      end
      default: begin
        // long sda low while awake is not looked at
        // busy clears once the engine finishes
        if (busy_reg && exec_done) begin
          busy_next = 1'b0;
          wptr_next = '0;
          cnt_next  = '0;
        end
        if (start_cond) begin
          pr_next  = sctp_pkg::SCTP_P_ADDR;
          bit_next = '0;
          ack_next = 1'b0;
        end else if (stop_cond) begin
          // an incomplete group only ends the transaction; its bytes stay
          pr_next  = sctp_pkg::SCTP_P_WAIT;
          ack_next = 1'b0;
          if (!busy_reg && cnt_reg != 7'd0 && wptr_reg >= cnt_reg) begin
            busy_next  = 1'b1;
            start_next = 1'b1;
          end
        end else begin
          case (pr_reg)
            sctp_pkg::SCTP_P_ADDR, sctp_pkg::SCTP_P_WORD, sctp_pkg::SCTP_P_DATA: begin
              if (scl_rise) begin
                sh_next  = {sh_reg[6:0], now_b.sda};
                bit_next = bit_reg + 4'd1;
              end else if (scl_fall && bit_reg == 4'd8) begin
                bit_next = '0;
                ret_next = pr_reg;
                pr_next  = sctp_pkg::SCTP_P_ACK;
                ack_next = 1'b0;
                if (pr_reg == sctp_pkg::SCTP_P_ADDR) begin
                  if (addr_hit(sh_reg) && !sh_reg[0]) begin
                    ack_next = 1'b1;
                    ret_next = sctp_pkg::SCTP_P_WORD;
                  // read refused while busy
                  // a refused read is the host's poll answer
                  end else if (addr_hit(sh_reg) && !busy_reg) begin
                    ack_next = 1'b1;
                    ret_next = sctp_pkg::SCTP_P_READ;
                  end else begin
                    ret_next = sctp_pkg::SCTP_P_WAIT;
                  end
                end else if (pr_reg == sctp_pkg::SCTP_P_WORD) begin
                  ack_next = 1'b1;
                  ret_next = sctp_pkg::SCTP_P_DATA;
                  if (sh_reg == sctp_pkg::WA_RESET) begin
                    // a reset during execution would lose the group, so it is ignored
                    if (!busy_reg) begin
                      wptr_next = '0;
                      cnt_next  = '0;
                    end
                  end else if (sh_reg == sctp_pkg::WA_SLEEP) begin
                    pwr_next  = sctp_pkg::SCTP_SLEEP;
                    keep_next = 1'b1;
                  // idle keeps key and seed stores
                  end else if (sh_reg == sctp_pkg::WA_IDLE) begin
                    pwr_next  = sctp_pkg::SCTP_IDLE;
                  // reserved word addresses leave the transfer unacknowledged
                  end else if (sh_reg != sctp_pkg::WA_COMMAND) begin
                    ack_next  = 1'b0;
                    ret_next  = sctp_pkg::SCTP_P_WAIT;
                  end
                  // leaving the awake state drops the ack at once and flushes the buffer
                  if (pwr_next != sctp_pkg::SCTP_AWAKE) begin
                    ack_next  = 1'b0;
                    tmr_next  = '0;
                    wptr_next = '0;
                    cnt_next  = '0;
                    pr_next   = sctp_pkg::SCTP_P_WAIT;
                  end
                // accept only within count and buffer
                end else if (!busy_reg && wptr_reg < 7'(BUF_DEPTH) &&
                             (cnt_reg == 7'd0 || wptr_reg < cnt_reg)) begin
                  ack_next  = 1'b1;
                  wr_en     = 1'b1;
                  wptr_next = wptr_reg + 7'd1;
                  // first byte holds group length
                  // the count byte counts itself, so a group of n bytes has count n
                  if (wptr_reg == 7'd0) begin
                    cnt_next = sh_reg[6:0];
                  end
                end
              end
            end
            sctp_pkg::SCTP_P_ACK: begin
              // hold ack through the ninth clock
              // released only after the ninth fall, so sda never moves while scl is high
              if (scl_fall) begin
                ack_next = 1'b0;
                pr_next  = ret_reg;
              end
            end
            sctp_pkg::SCTP_P_READ: begin
              // output path lies outside this port; release sda
              // a stalled read therefore never holds the bus
              ack_next = 1'b0;
            end
            default: begin
              ack_next = 1'b0;
            end
          endcase
        end
        // open drain: only ever pull low
        sda_next = ack_next && pwr_next == sctp_pkg::SCTP_AWAKE;
      end
    endcase
    // asleep follows the next power state, so it agrees with sda_oe
    asleep_next = (pwr_next != sctp_pkg::SCTP_AWAKE);
  end

  // ==========================================================================
  // registers
  // synchronous reset: the port starts asleep, like a cold power-up
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_reg   <= sctp_pkg::SCTP_SLEEP;
      pr_reg    <= sctp_pkg::SCTP_P_WAIT;
      ret_reg   <= sctp_pkg::SCTP_P_WAIT;
      tmr_reg   <= '0;
      bit_reg   <= '0;
      sh_reg    <= '0;
      wptr_reg  <= '0;
      cnt_reg   <= '0;
      ack_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      start_reg <= 1'b0;
      sda_reg   <= 1'b0;
      keep_reg  <= 1'b0;
      asleep_reg <= 1'b1;
    end else begin
      pwr_reg   <= pwr_next;
      pr_reg    <= pr_next;
      ret_reg   <= ret_next;
      tmr_reg   <= tmr_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      wptr_reg  <= wptr_next;
      cnt_reg   <= cnt_next;
      ack_reg   <= ack_next;
      busy_reg  <= busy_next;
      start_reg <= start_next;
      sda_reg   <= sda_next;
      keep_reg  <= keep_next;
      asleep_reg <= asleep_next;
    end
  end

  // input buffer storage, indexed by the fifo pointer
  // read by the execution engine stage, which lies outside this port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wptr_reg] <= sh_reg;
    end
  end

  // ==========================================================================
  // outputs
  // every output but the constant sda_out comes from a register
  // exec_count stands from the first byte until the group is done
  assign sda_out    = 1'b0;        // never drives high
  assign sda_oe     = sda_reg;
  assign exec_start = start_reg;
  assign exec_count = cnt_reg;
  assign busy       = busy_reg;
  assign asleep     = asleep_reg;
  assign keep_clear = keep_reg;

endmodule : sctp_target

// ---- shared/sctp_pkg.sv ----
// sctp_pkg: constants and carrier types for the coprocessor i2c target port
// assumes: one 50 MHz core clock; scl and sda arrive asynchronously from pins
package sctp_pkg;

  // ==========================================================================
  // timing and sizes
  localparam int CLK_MHZ             = 50;
  localparam int BUF_BYTES           = 71;
  localparam int WAKE_LOW_CYCLES     = 3000;   // wake_low_time, core cycles
  localparam int WAKE_READY_CYCLES   = 75000;  // wake_ready_delay, core cycles
  localparam int EXEC_CYCLES         = 50000;  // command_execution_time, core cycles

  // ==========================================================================
  // word address functions
  localparam logic [7:0] WA_RESET    = 8'h00;
  localparam logic [7:0] WA_SLEEP    = 8'h01;
  localparam logic [7:0] WA_IDLE     = 8'h02;
  localparam logic [7:0] WA_COMMAND  = 8'h03;
  localparam logic [7:0] READ_FILL   = 8'hFF;
  localparam logic [6:0] ADDR_RESET  = 7'h60;  // default bus address, arbitrary

  // ==========================================================================
  // power and protocol states
  typedef enum logic [1:0] {SCTP_SLEEP, SCTP_IDLE, SCTP_WAKING, SCTP_AWAKE} sctp_pwr_t;
  typedef enum logic [2:0] {SCTP_P_WAIT, SCTP_P_ADDR, SCTP_P_WORD, SCTP_P_DATA,
                            SCTP_P_READ, SCTP_P_ACK} sctp_proto_t;

  // synchronised bus view
  typedef struct packed {
    logic scl;
    logic sda;
  } sctp_bus_t;

  // command handed to the execution engine
  typedef struct packed {
    logic       start;
    logic [6:0] count;
  } sctp_cmd_t;

endpackage : sctp_pkg

// ---- sim/sctp_host.sv ----
// sctp_host: behavioural i2c bus master driving the target port
// assumes: sda has a pull-up; the bench wires all pull-downs together
`timescale 1ns/1ps
module sctp_host #(
  parameter int HALF_NS = 80,
  parameter int WAKE_NS = 600
) (
  // bus pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  // bus idles released, clock standing high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wake();
    sda_low = 1'b1;
    #(WAKE_NS);
    sda_low = 1'b0;
  endtask : wake
  task automatic start();
    sda_low = 1'b0;
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b1;
    #(HALF_NS);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b0;
    #(HALF_NS);
  endtask : stop
  // byte msb first, ack sampled late in ninth high
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      #(HALF_NS);
      scl = 1'b1;
      #(HALF_NS);
      scl = 1'b0;
    end
    sda_low = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS - 5);
    ack = !sda_line;
    #5;
    scl = 1'b0;
    // clock stands low a while so the target lets go of its ack first
    #(HALF_NS);
  endtask : xfer
endmodule : sctp_host

// ---- sim/sctp_target_sva.sv ----
// sctp_target_sva: port-level checks for the i2c target port
// assumes: bound to sctp_target, one core clock, synchronous active-high reset
`timescale 1ns/1ps
module sctp_target_sva #(
  parameter int WAKE_READY = 50
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // execution engine
  input wire logic       exec_done,
  input wire logic       exec_start,
  input wire logic [6:0] exec_count,
  input wire logic       busy,
  input wire logic       asleep,
  input wire logic       keep_clear
);
  // ==========================================================================
  // helpers
  logic [3:0]  age_reg, age_next;
  logic [19:0] nap_reg, nap_next;
  logic        scl_reg, sda_reg;
  // raw stop age saturates, so an old stop never looks fresh
  always_comb begin
    age_next = (scl_reg && scl_in && !sda_reg && sda_in) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
    nap_next = asleep ? nap_reg + 20'h0_0001 : 20'h0_0000;
    if (reset) begin
      age_next = 4'hf;
      nap_next = 20'h0_0000;
    end
  end
  // register helpers
  always_ff @(posedge core_clk) begin
    age_reg <= age_next;
    nap_reg <= nap_next;
    scl_reg <= scl_in;
    sda_reg <= sda_in;
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_asleep_no_ack: assert property (asleep |-> !sda_oe)
    else $error("ack while not awake");
  a_ack_drop_low: assert property ($fell(sda_oe) |-> !$past(scl_in, 2))
    else $error("ack released during clock high");
  a_exec_one_pulse: assert property (exec_start |=> !exec_start)
    else $error("start pulse too long");
  a_exec_after_stop: assert property (exec_start |-> age_reg < 4'h8 && !$past(busy))
    else $error("start without fresh stop");
  a_busy_follows: assert property (exec_start |=> busy)
    else $error("busy missing after start");
  a_busy_holds: assert property (busy && !exec_done |=> busy)
    else $error("busy dropped early");
  a_wake_ready: assert property ($fell(asleep) |-> nap_reg >= 20'(WAKE_READY))
    else $error("awake too soon");
  a_sleep_clears: assert property (keep_clear |-> ##[0:4] asleep)
    else $error("clear without sleep");
  a_count_given: assert property (exec_start |-> exec_count != 7'h00)
    else $error("start with zero count");
endmodule : sctp_target_sva

bind sctp_target sctp_target_sva #(.WAKE_READY(WAKE_READY)) u_sva (.core_clk, .reset, .scl_in, .sda_in,
  .sda_out, .sda_oe, .exec_done, .exec_start, .exec_count, .busy, .asleep, .keep_clear);

// ---- sim/sctp_target_test.sv ----
// sctp_target_test: self-checking bench for the coprocessor i2c target port
// assumes: host model on the bus, bench plays the execution engine
`timescale 1ns/1ps
module sctp_target_test;
  // row: first, ack, last, pad, then the byte
  typedef struct packed {logic first; logic ack; logic last; logic pad; logic [7:0] b;} sctp_row_t;
  logic       core_clk, reset, exec_done, scl, host_low, sda_line, sda_out, sda_oe;
  logic       exec_start, busy, asleep, keep_clear, got;
  logic [6:0] exec_count, last_count;
  int         fail_count, n_compared, n_starts, n_clears;
  sctp_row_t  rows [12] = '{12'hAA0, 12'hCC0, 12'h600, 12'hCC0, 12'h403, 12'h404,
                            12'h611, 12'hCC0, 12'h403, 12'h422, 12'h433, 12'h244};

  // ==========================================================================
  // design, host and open-drain bus
  sctp_target #(.WAKE_LOW(20), .WAKE_READY(50)) dut (.core_clk(core_clk), .reset(reset), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .exec_done(exec_done), .exec_start(exec_start),
    .exec_count(exec_count), .busy(busy), .asleep(asleep), .keep_clear(keep_clear));
  sctp_host host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));
  assign sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  // clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // watchdog: whole run needs well under a millisecond
  initial begin
    #1_000_000;
    fail_count++;
    finish_test();
  end
  // one-cycle pulses are counted on the edge they stand
  always @(posedge core_clk) begin
    if (exec_start === 1'b1) begin
      n_starts++;
      last_count = exec_count;
    end
    if (keep_clear === 1'b1) n_clears++;
  end

  // ==========================================================================
  // tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic send(input logic [7:0] b, input logic exp);
    host.xfer(b, got);
    check(got, exp);
  endtask : send
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // main sequence
  initial begin
    reset = 1'b1;
    exec_done = 1'b0;
    cyc(4);
    reset = 1'b0;
    check(asleep, 1);
    check(busy, 0);
    host.wake();
    cyc(60);
    check(asleep, 0);
    // wrong address, pointer reset, then one group split over two writes
    // only legal word addresses are sent
    foreach (rows[k]) begin
      if (rows[k].first) host.start();
      send(rows[k].b, rows[k].ack);
      if (rows[k].last) host.stop();
    end
    cyc(8);
    check(8'(n_starts), 1);
    check(last_count, 4);
    check(busy, 1);
    host.start();
    send(8'hC1, 0);
    host.stop();
    exec_done = 1'b1;
    cyc(1);
    exec_done = 1'b0;
    cyc(3);
    check(busy, 0);
    // execution waited out, then an ordinary read
    host.start();
    send(8'hC1, 1);
    host.xfer(8'hFF, got);
    host.stop();
    host.start();
    send(8'hC0, 1);
    send(8'h01, 0);
    host.stop();
    cyc(8);
    check(8'(n_clears), 1);
    check(asleep, 1);
    host.start();
    send(8'hC1, 0);
    host.stop();
    host.wake();
    cyc(60);
    check(asleep, 0);
    host.start();
    send(8'hC0, 1);
    send(8'h02, 0);
    host.stop();
    cyc(8);
    check(asleep, 1);
    check(8'(n_clears), 1);
    finish_test();
  end
endmodule : sctp_target_test
